// File: design/fpes_status.v
// Program/erase status word: flags, suspend tracking and latched read-out
`include "fpes_map.vh"

module fpes_status #(
  parameter DATA_W = `FPES_DATA_W,
  parameter BANK_W = `FPES_BANK_W
) (
  input  wire              i_clk,
  input  wire              i_rst_n,
  input  wire              i_chip_en_n,
  input  wire              i_out_en_n,
  input  wire [BANK_W-1:0] i_read_bank,
  input  wire              i_vpp_above_lockout,
  input  wire              i_vpp_high_level,
  input  wire [DATA_W-1:0] i_array_data,
  input  wire              i_status_read_mode,
  input  wire              i_op_start,
  input  wire              i_op_is_erase,
  input  wire [BANK_W-1:0] i_op_bank,
  input  wire              i_block_locked,
  input  wire              i_op_done,
  input  wire              i_suspend_req,
  input  wire              i_ctrl_paused,
  input  wire              i_resume_req,
  input  wire              i_clear_status,
  input  wire              i_erase_pulse_fail,
  input  wire              i_program_pulse_fail,
  input  wire              i_program_one_on_zero,
  input  wire              i_factory_enter,
  input  wire              i_factory_exit,
  input  wire              i_factory_word_busy,
  output reg  [DATA_W-1:0] o_data,
  output reg               o_data_oe,
  output reg               o_op_go,
  output reg               o_op_refused,
  output reg               o_controller_ready,
  output reg               o_factory_program_mode
);
  localparam [3:0] ST_IDLE       = 4'h1;
  localparam [3:0] ST_BUSY       = 4'h2;
  localparam [3:0] ST_SUSPENDING = 4'h4;
  localparam [3:0] ST_SUSPENDED  = 4'h8;

  // Pins from outside the clock domain
  wire              ce_n_s;
  wire              oe_n_s;
  wire              vpp_ok_s;
  wire              vpp_high_s;
  wire [BANK_W-1:0] read_bank_s;

  // Enables reset to their idle high level, so no false fall follows reset
  fpes_pin_sync #(
    .W         (4),
    .RESET_VAL (4'hC)
  ) u_ctl_sync (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_pin   ({i_chip_en_n, i_out_en_n, i_vpp_above_lockout, i_vpp_high_level}),
    .o_level ({ce_n_s, oe_n_s, vpp_ok_s, vpp_high_s})
  );

  fpes_pin_sync #(
    .W         (BANK_W),
    .RESET_VAL ({BANK_W{1'b0}})
  ) u_bank_sync (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_pin   (i_read_bank),
    .o_level (read_bank_s)
  );

  reg [3:0]        state;
  reg [3:0]        next_state;
  reg [BANK_W-1:0] op_bank;
  reg              op_erase;
  reg              vpp_high_sampled;
  reg              erase_suspended_flag;
  reg              program_suspended_flag;
  reg              erase_fail_flag;
  reg              program_fail_flag;
  reg              supply_fail_flag;
  reg              locked_block_fail_flag;
  reg              factory_program_mode;
  reg              ce_n_d;
  reg              oe_n_d;
  reg [`FPES_SW_W-1:0] held_word;
  reg              show_status;

  wire any_error = erase_fail_flag | program_fail_flag | supply_fail_flag | locked_block_fail_flag;
  wire controller_ready_flag = state[0] | state[3];
  wire pe_active = state[1] | state[2];

  // Start is taken only when idle; the checks below decide go or refuse
  wire start_ok   = state[0] & i_op_start;
  wire refuse_sup = start_ok & ~vpp_ok_s;
  wire refuse_lck = start_ok & vpp_ok_s & i_block_locked;
  wire refuse_err = start_ok & any_error;
  wire go         = start_ok & vpp_ok_s & ~i_block_locked & ~any_error;

  // Bit zero depends on the address presented now, so it is worked out per read
  reg bank_write_or_word_ready_flag;
  always @*
  begin
    if (factory_program_mode & pe_active)
      bank_write_or_word_ready_flag = i_factory_word_busy;
    else if (pe_active)
      bank_write_or_word_ready_flag = (read_bank_s != op_bank);
    else
      bank_write_or_word_ready_flag = 1'b0;
  end

  wire [`FPES_SW_W-1:0] live_word = {controller_ready_flag,
                                     erase_suspended_flag,
                                     erase_fail_flag,
                                     program_fail_flag,
                                     supply_fail_flag,
                                     program_suspended_flag,
                                     locked_block_fail_flag,
                                     bank_write_or_word_ready_flag};

  always @*
  begin
    next_state = state;
    case (state)
      ST_IDLE:
      begin
        if (go)
          next_state = ST_BUSY;
      end
      ST_BUSY:
      begin
        if (i_op_done)
          next_state = ST_IDLE;
        else if (i_suspend_req)
          next_state = ST_SUSPENDING;
      end
      ST_SUSPENDING:
      begin
        if (i_op_done)
          next_state = ST_IDLE;
        else if (i_ctrl_paused)
          next_state = ST_SUSPENDED;
      end
      ST_SUSPENDED:
      begin
        if (i_resume_req)
          next_state = ST_BUSY;
      end
      default:
        next_state = ST_IDLE;
    endcase
  end

  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state            <= ST_IDLE;
      op_bank          <= {BANK_W{1'b0}};
      op_erase         <= 1'b0;
      vpp_high_sampled <= 1'b0;
    end
    else
    begin
      state <= next_state;
      if (go)
      begin
        op_bank          <= i_op_bank;
        op_erase         <= i_op_is_erase;
        vpp_high_sampled <= vpp_high_s;
      end
    end
  end

  // Suspend flags follow the controller; a late finish never raises them
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      erase_suspended_flag   <= 1'b0;
      program_suspended_flag <= 1'b0;
    end
    else
    begin
      if (state[2] & ~i_op_done & i_ctrl_paused)
      begin
        erase_suspended_flag   <= op_erase;
        program_suspended_flag <= ~op_erase;
      end
      else if (state[3] & i_resume_req)
      begin
        erase_suspended_flag   <= 1'b0;
        program_suspended_flag <= 1'b0;
      end
    end
  end

  // Error flags: a set in the same cycle as a clear wins, so no failure is lost
  wire set_erase_fail = pe_active & i_erase_pulse_fail;
  wire set_prog_fail  = pe_active & (i_program_pulse_fail |
                        (i_program_one_on_zero & vpp_high_sampled));

  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      erase_fail_flag        <= 1'b0;
      program_fail_flag      <= 1'b0;
      supply_fail_flag       <= 1'b0;
      locked_block_fail_flag <= 1'b0;
    end
    else
    begin
      erase_fail_flag        <= set_erase_fail | (erase_fail_flag & ~i_clear_status);
      program_fail_flag      <= set_prog_fail | (program_fail_flag & ~i_clear_status);
      supply_fail_flag       <= refuse_sup | (supply_fail_flag & ~i_clear_status);
      locked_block_fail_flag <= refuse_lck | (locked_block_fail_flag & ~i_clear_status);
    end
  end

  // Factory mode ends on its exit write or when the controller goes idle
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      factory_program_mode <= 1'b0;
    else if (i_factory_exit | (pe_active & (next_state == ST_IDLE)))
      factory_program_mode <= 1'b0;
    else if (pe_active & i_factory_enter)
      factory_program_mode <= 1'b1;
  end

  // Read-out: the word is captured when either enable falls and then held
  wire ce_fall = ce_n_d & ~ce_n_s;
  wire oe_fall = oe_n_d & ~oe_n_s;
  wire capture = ce_fall | oe_fall;
  wire bank_busy_read = pe_active & (read_bank_s == op_bank);

  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ce_n_d      <= 1'b1;
      oe_n_d      <= 1'b1;
      held_word   <= `FPES_SW_RESET;
      show_status <= 1'b0;
    end
    else
    begin
      ce_n_d <= ce_n_s;
      oe_n_d <= oe_n_s;
      if (capture)
      begin
        held_word   <= live_word;
        show_status <= i_status_read_mode | bank_busy_read;
      end
    end
  end

  // Outputs are registered; array data passes live while status stays frozen
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_data                 <= {DATA_W{1'b0}};
      o_data_oe              <= 1'b0;
      o_op_go                <= 1'b0;
      o_op_refused           <= 1'b0;
      o_controller_ready     <= 1'b1;
      o_factory_program_mode <= 1'b0;
    end
    else
    begin
      o_data_oe <= ~ce_n_s & ~oe_n_s;
      if (show_status)
        o_data <= {{(DATA_W-`FPES_SW_W){1'b0}}, held_word};
      else
        o_data <= i_array_data;
      o_op_go                <= go;
      o_op_refused           <= refuse_sup | refuse_lck | refuse_err;
      o_controller_ready     <= controller_ready_flag;
      o_factory_program_mode <= factory_program_mode;
    end
  end
endmodule

// File: pkg/fpes_map.vh
// Bit map, reset values and widths of the program/erase status word
// Behaviour
// - Latch status on enable fall, hold until high
// - Busy bank reads return the status word
// - Device sets and clears the state flags
// - Error flags stick until clear or reset
// - Bits 7..1 device-wide, bit 0 addressed bank
// - Ready low while controller active, else high
// - After suspend, ready low until controller paused
// - Erase suspended set on pause, cleared on resume
// - Late suspend may finish, flag stays clear
// - Erase pulse limit failure sets erase fail
// - Commands fail while any error flag set
// - Program pulse limit failure sets program fail
// - One onto zero fails only at high supply
// - Supply pin sampled once at operation start
// - Supply below lockout sets flag, refuses operation
// - Program suspended set on pause, cleared on resume
// - Operation on locked block sets protection flag
// - Busy: bit 0 low same bank, high other
// - Factory mode: bit 0 low when word accepted
// - Factory mode exit: ready high, bit 0 low; exit write keeps ready low and bit 0 the bank compare until done
`ifndef FPES_MAP_VH
`define FPES_MAP_VH

`define FPES_SW_W          8
`define FPES_BIT_READY     7
`define FPES_BIT_ERS_SUSP  6
`define FPES_BIT_ERS_FAIL  5
`define FPES_BIT_PRG_FAIL  4
`define FPES_BIT_SUP_FAIL  3
`define FPES_BIT_PRG_SUSP  2
`define FPES_BIT_LOCK_FAIL 1
`define FPES_BIT_BANK      0
`define FPES_SW_RESET      8'h80
`define FPES_DATA_W        16
`define FPES_BANK_W        3
`define FPES_SYNC_STAGES   3

`endif

// File: design/fpes_pin_sync.v
// Three-stage pin synchroniser that accepts a change once stages two and three agree
module fpes_pin_sync #(
  parameter W = 1,
  parameter [W-1:0] RESET_VAL = {W{1'b0}}
) (
  input  wire         i_clk,
  input  wire         i_rst_n,
  input  wire [W-1:0] i_pin,
  output wire [W-1:0] o_level
);
  reg [W-1:0] stage1;
  reg [W-1:0] stage2;
  reg [W-1:0] stage3;
  reg [W-1:0] level;

  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      stage1 <= RESET_VAL;
      stage2 <= RESET_VAL;
      stage3 <= RESET_VAL;
    end
    else
    begin
      stage1 <= i_pin;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  genvar b;
  generate
    for (b = 0; b < W; b = b + 1)
    begin : g_bit
      // A bit only moves once the last two stages agree, filtering one-stage glitches
      always @(posedge i_clk or negedge i_rst_n)
      begin
        if (!i_rst_n)
          level[b] <= RESET_VAL[b];
        else if (stage2[b] == stage3[b])
          level[b] <= stage3[b];
      end
    end
  endgenerate

  assign o_level = level;
endmodule

// File: verification/fpes_status_properties.sv
// Concurrent checks on the ports of the status block
module fpes_status_properties (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_chip_en_n,
  input wire i_out_en_n,
  input wire i_vpp_above_lockout,
  input wire i_op_start,
  input wire i_op_done,
  input wire i_suspend_req,
  input wire i_factory_enter,
  input wire o_data_oe,
  input wire o_op_go,
  input wire o_op_refused,
  input wire o_controller_ready,
  input wire o_factory_program_mode
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  sequence s_idle_start;
    i_op_start && o_controller_ready;
  endsequence
  sequence s_answer;
    o_op_go || o_op_refused;
  endsequence
  sequence s_suspend;
    i_suspend_req && !o_controller_ready && !i_op_done;
  endsequence
  // Starts while suspended are not exercised, so ready high means idle here
  property p_answer;
    s_idle_start |=> s_answer;
  endproperty
  property p_go_busy;
    o_op_go |=> !o_controller_ready;
  endproperty
  property p_go_single;
    o_op_go |=> !o_op_go && !o_op_refused;
  endproperty
  property p_supply;
    s_idle_start and !i_vpp_above_lockout && !$past(i_vpp_above_lockout, 6) |=> o_op_refused;
  endproperty
  property p_done_ready;
    i_op_done && !o_controller_ready && !o_op_go |-> ##[1:2] o_controller_ready;
  endproperty
  property p_suspend_low;
    s_suspend |=> !o_controller_ready [*2];
  endproperty
  property p_oe_rise;
    $rose(o_data_oe) |-> !$past(i_chip_en_n, 2) && !$past(i_out_en_n, 2);
  endproperty
  property p_factory;
    $rose(o_factory_program_mode) |-> $past(i_factory_enter, 2) && !o_controller_ready;
  endproperty
  a_answer: assert property (p_answer) else $error("start from idle got no answer");
  a_go_busy: assert property (p_go_busy) else $error("ready high after accepted start");
  a_go_single: assert property (p_go_single) else $error("start answer not one cycle");
  a_supply: assert property (p_supply) else $error("low supply start not refused");
  a_done_ready: assert property (p_done_ready) else $error("ready not high after done");
  a_suspend_low: assert property (p_suspend_low) else $error("ready rose before pause");
  a_oe_rise: assert property (p_oe_rise) else $error("output enable without both enables low");
  a_factory: assert property (p_factory) else $error("factory mode without enter");
endmodule

bind fpes_status fpes_status_properties chk_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_chip_en_n(i_chip_en_n),
  .i_out_en_n(i_out_en_n), .i_vpp_above_lockout(i_vpp_above_lockout), .i_op_start(i_op_start),
  .i_op_done(i_op_done), .i_suspend_req(i_suspend_req), .i_factory_enter(i_factory_enter),
  .o_data_oe(o_data_oe), .o_op_go(o_op_go), .o_op_refused(o_op_refused),
  .o_controller_ready(o_controller_ready), .o_factory_program_mode(o_factory_program_mode));

// File: verification/fpes_host_model.sv
// Host side model doing single asynchronous reads of the status word
module fpes_host_model (
  input  wire        i_clk,
  input  wire        i_req,
  input  wire [2:0]  i_bank,
  input  wire [15:0] i_data,
  output reg         o_chip_en_n,
  output reg         o_out_en_n,
  output reg  [2:0]  o_read_bank,
  output reg  [15:0] o_word,
  output reg         o_done
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    o_chip_en_n = 1'b1;
    o_out_en_n = 1'b1;
    o_read_bank = 3'h0;
    o_word = 16'h0000;
    o_done = 1'b0;
  end
  // One word per enable low phase, never a burst
  always @(posedge i_clk)
  begin
    if (i_req)
    begin
      @(negedge i_clk);
      o_read_bank = i_bank;
      o_chip_en_n = 1'b0;
      o_out_en_n = 1'b0;
      repeat (8) @(posedge i_clk);
      @(negedge i_clk);
      o_word = i_data;
      o_chip_en_n = 1'b1;
      o_out_en_n = 1'b1;
      // Released address shows a changed value, not the last one
      o_read_bank = ~i_bank;
      o_done = 1'b1;
      @(negedge i_clk);
      o_done = 1'b0;
    end
  end
endmodule

// File: verification/testbench.sv
// Self-checking bench for the program/erase status word
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, req = 0, erase = 0, locked = 0, vpp_ok = 1, vpp_hi = 0, sm = 0, wbusy = 0;
  logic [10:0] pv = 11'h000;
  logic [2:0] bank = 3'h0, op_bank = 3'h0, rb;
  logic [15:0] data, word;
  logic ce_n, oe_n, oe, go, refused, ready, fmode, done;
  int err_count = 0, compares = 0, n_go = 0, n_ref = 0, eg = 0, er = 0, i;
  int ek[3] = '{7, 6, 8};
  logic [15:0] ew[3] = '{16'h0090, 16'h00A0, 16'h0090};
  always #20 clk = ~clk;
  fpes_host_model host_u (.i_clk(clk), .i_req(req), .i_bank(bank), .i_data(data), .o_chip_en_n(ce_n),
    .o_out_en_n(oe_n), .o_read_bank(rb), .o_word(word), .o_done(done));
  fpes_status dut_u (.i_clk(clk), .i_rst_n(rst_n), .i_chip_en_n(ce_n), .i_out_en_n(oe_n), .i_read_bank(rb),
    .i_vpp_above_lockout(vpp_ok), .i_vpp_high_level(vpp_hi), .i_array_data(16'hA5C3),
    .i_status_read_mode(sm), .i_op_start(pv[0]), .i_op_is_erase(erase), .i_op_bank(op_bank),
    .i_block_locked(locked), .i_op_done(pv[1]), .i_suspend_req(pv[2]), .i_ctrl_paused(pv[3]),
    .i_resume_req(pv[4]), .i_clear_status(pv[5]), .i_erase_pulse_fail(pv[6]), .i_program_pulse_fail(pv[7]),
    .i_program_one_on_zero(pv[8]), .i_factory_enter(pv[9]), .i_factory_exit(pv[10]),
    .i_factory_word_busy(wbusy), .o_data(data), .o_data_oe(oe), .o_op_go(go), .o_op_refused(refused),
    .o_controller_ready(ready), .o_factory_program_mode(fmode));
  always @(posedge clk)
  begin
    if (go === 1'b1) n_go++;
    if (refused === 1'b1) n_ref++;
  end
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic pulse(input int k);
    @(negedge clk);
    pv = 11'h001 << k;
    @(negedge clk);
    pv = 11'h000;
    repeat (3) @(negedge clk);
  endtask
  task automatic st(input logic e, input logic [2:0] b, input logic l, input logic ok);
    erase = e;
    op_bank = b;
    locked = l;
    pulse(0);
    if (ok) eg++;
    else er++;
    check("go count", n_go[15:0], eg[15:0]);
    check("refused count", n_ref[15:0], er[15:0]);
  endtask
  task automatic rd(input logic s, input logic [2:0] b, input logic [15:0] exp);
    int n;
    @(negedge clk);
    sm = s;
    bank = b;
    req = 1;
    @(negedge clk);
    req = 0;
    for (n = 0; n < 30 && done !== 1'b1; n++) @(posedge clk);
    @(negedge clk);
    check("read word", word, exp);
    check("output enable", {15'h0000, oe}, 16'h0001);
  endtask
  task automatic end_of_test();
    $display("counts: compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    #800000;
    err_count++;
    end_of_test();
  end
  initial
  begin
    repeat (2) @(negedge clk);
    rst_n = 1;
    @(negedge clk);
    check("oe after reset", {15'h0000, oe}, 16'h0000);
    check("ready after reset", {15'h0000, ready}, 16'h0001);
    repeat (6) @(negedge clk);
    rd(1, 3'h0, 16'h0080);
    st(0, 3'h2, 0, 1);
    rd(0, 3'h2, 16'h0000);
    rd(1, 3'h5, 16'h0001);
    rd(0, 3'h5, 16'hA5C3);
    pulse(1);
    rd(1, 3'h2, 16'h0080);
    $display("test busy bank done");
    for (i = 0; i < 2; i++)
    begin
      st(i[0], 3'h1, 0, 1);
      pulse(2);
      rd(1, 3'h1, 16'h0000);
      pulse(3);
      rd(1, 3'h1, i[0] ? 16'h00C0 : 16'h0084);
      pulse(4);
      rd(1, 3'h1, 16'h0000);
      pulse(1);
    end
    st(1, 3'h1, 0, 1);
    pulse(2);
    pulse(1);
    rd(1, 3'h1, 16'h0080);
    $display("test suspend done");
    vpp_hi = 1;
    repeat (6) @(negedge clk);
    for (i = 0; i < 3; i++)
    begin
      st(0, 3'h3, 0, 1);
      pulse(ek[i]);
      pulse(1);
      check("ready before error read", {15'h0000, ready}, 16'h0001);
      rd(1, 3'h3, ew[i]);
      st(0, 3'h3, 0, 0);
      rd(1, 3'h3, ew[i]);
      pulse(5);
      rd(1, 3'h3, 16'h0080);
    end
    vpp_hi = 0;
    repeat (6) @(negedge clk);
    st(0, 3'h3, 0, 1);
    pulse(8);
    pulse(1);
    rd(1, 3'h3, 16'h0080);
    $display("test error flags done");
    vpp_ok = 0;
    repeat (6) @(negedge clk);
    st(0, 3'h1, 0, 0);
    rd(1, 3'h1, 16'h0088);
    vpp_ok = 1;
    pulse(5);
    repeat (6) @(negedge clk);
    st(0, 3'h1, 0, 1);
    vpp_ok = 0;
    repeat (6) @(negedge clk);
    pulse(1);
    rd(1, 3'h1, 16'h0080);
    vpp_ok = 1;
    repeat (6) @(negedge clk);
    st(0, 3'h1, 1, 0);
    rd(1, 3'h1, 16'h0082);
    pulse(5);
    $display("test supply and lock done");
    st(0, 3'h2, 0, 1);
    pulse(9);
    check("factory mode", {15'h0000, fmode}, 16'h0001);
    wbusy = 1;
    rd(1, 3'h2, 16'h0001);
    wbusy = 0;
    rd(1, 3'h2, 16'h0000);
    pulse(10);
    check("factory mode", {15'h0000, fmode}, 16'h0000);
    pulse(1);
    rd(1, 3'h2, 16'h0080);
    $display("test factory mode done");
    end_of_test();
  end
endmodule
